// file: rtl/cclpc_pkg.sv
// Package: constants and types for the core cluster low-power controller
package cclpc_pkg;

  // ****************************************
  // Core power states
  // ****************************************
  typedef enum logic [2:0] {
    CCLPC_RUN      = 3'b000,
    CCLPC_LIGHT    = 3'b001,
    CCLPC_DEEP_ENT = 3'b010,
    CCLPC_DEEP     = 3'b011,
    CCLPC_WAKE_PWR = 3'b100,
    CCLPC_WAKE_CLK = 3'b101
  } cclpc_state_t;

  // ****************************************
  // Requested state codes on the write port
  // ****************************************
  localparam logic [1:0] REQ_RUN   = 2'h0;
  localparam logic [1:0] REQ_LIGHT = 2'h1;
  localparam logic [1:0] REQ_DEEP  = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ           = 50;
  // Deep sleep exit budget in platform clocks
  localparam int DEEP_EXIT_CYCLES  = 100;
  // Supply ramp and clock restore split of the exit budget
  localparam int PWR_RAMP_CYCLES   = 60;
  localparam int CLK_RESTORE_CYCLES = 30;
  // Transmit inactivity before low power idle, in microseconds
  localparam int TX_IDLE_US        = 20;
  localparam int TX_IDLE_CYCLES    = TX_IDLE_US * CLK_MHZ;

  // Reset values
  localparam logic [7:0] VID_DEFAULT = 8'h5A; // arbitrary value

endpackage

// file: rtl/cclpc_ctrl.sv
// Module: core cluster low-power controller
`timescale 1ns/1ns
module cclpc_ctrl #(
  parameter int NCORES = 4,
  parameter int NBLK   = 8,
  parameter int QW     = 16,
  parameter int TX_IDLE_CYCLES = cclpc_pkg::TX_IDLE_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Power request write port
  input  wire logic              req_valid_i,
  input  wire logic [$clog2(NCORES)-1:0] req_src_i,
  input  wire logic [$clog2(NCORES)-1:0] req_core_i,
  input  wire logic [1:0]        req_state_i,
  input  wire logic [NCORES-1:0] req_perm_i,
  input  wire logic              cluster_deep_req_i,
  input  wire logic              l2_flushed_i,
  // Per core thread wait and wake events
  input  wire logic [NCORES-1:0] wait_t0_i,
  input  wire logic [NCORES-1:0] wait_t1_i,
  input  wire logic [NCORES-1:0] ext_trig_i,
  input  wire logic [NCORES-1:0] irq_i,
  input  wire logic [NCORES-1:0] doorbell_i,
  input  wire logic [NCORES-1:0] stash_i,
  input  wire logic [NCORES-1:0] resv_clr_i,
  // Queue pool
  input  wire logic [QW-1:0]     pool_depth_i,
  input  wire logic [QW-1:0]     pool_thresh_i,
  // Blocks: work dispatch and static disable
  input  wire logic [NBLK-1:0]   blk_work_i,
  input  wire logic [NBLK-1:0]   blk_disable_i,
  // Ethernet transmit activity
  input  wire logic              tx_active_i,
  // Core controls
  output logic [NCORES-1:0]      fetch_en_o,
  output logic [NCORES-1:0]      snoop_en_o,
  output logic [NCORES-1:0]      core_clk_en_o,
  output logic [NCORES-1:0]      core_pwr_full_o,
  output logic [NCORES-1:0]      retain_o,
  output logic [NCORES-1:0]      core_asleep_o,
  output logic                   cluster_deep_o,
  output logic [NCORES-1:0]      pool_wake_o,
  // Block clocks, transmit idle, voltage ID
  output logic [NBLK-1:0]        blk_clk_en_o,
  output logic                   tx_lpi_o,
  output logic [7:0]             vid_o
);

  if (NCORES < 2 || NBLK < 1 || QW < 1 || TX_IDLE_CYCLES < 1) begin : g_chk
    $error("cclpc_ctrl: unsupported parameters");
  end

  localparam int CW = $clog2(cclpc_pkg::DEEP_EXIT_CYCLES + 1);
  localparam int TW = $clog2(TX_IDLE_CYCLES + 1);

  // ****************************************
  // Input synchronisers for pin-level events
  // ****************************************
  logic [NCORES-1:0] trig_s1, trig_s2;
  logic              tx_s1, tx_s2;
  always_ff @(posedge clk_i) begin
    trig_s1 <= ext_trig_i;
    trig_s2 <= trig_s1;
    tx_s1   <= tx_active_i;
    tx_s2   <= tx_s1;
  end

  // ****************************************
  // Request decode
  // ****************************************
  wire req_ok = req_valid_i && req_perm_i[req_src_i];
  wire all_light;
  wire cl_go = cluster_deep_req_i && all_light && l2_flushed_i;

  cclpc_pkg::cclpc_state_t st [NCORES];
  cclpc_pkg::cclpc_state_t next_st [NCORES];
  logic [NCORES-1:0] by_reg;
  logic [NCORES-1:0] next_by_reg;
  logic [NCORES-1:0] t0w, t1w;
  logic [CW-1:0]     cnt [NCORES];
  logic [CW-1:0]     next_cnt [NCORES];
  logic [NCORES-1:0] light_v, wake_v, wake_wr;

  // ****************************************
  // Pool wake: lowest numbered sleeping core
  // ****************************************
  wire over = pool_depth_i > pool_thresh_i;
  logic [NCORES-1:0] lowest;
  always_comb begin
    lowest = '0;
    for (int i = NCORES - 1; i >= 0; i--) begin
      if (st[i] != cclpc_pkg::CCLPC_RUN) begin
        lowest = '0;
        lowest[i] = over;
      end
    end
  end

  // ****************************************
  // Per-core sequencer
  // ****************************************
  always_comb begin
    for (int i = 0; i < NCORES; i++) begin
      wake_wr[i] = req_ok && req_core_i == i[$clog2(NCORES)-1:0] &&
                   req_state_i == cclpc_pkg::REQ_RUN &&
                   (req_src_i != i[$clog2(NCORES)-1:0] || !by_reg[i]);
      // A core woken by its own write is never this core's own event
      wake_v[i] = trig_s2[i] | irq_i[i] | doorbell_i[i] | stash_i[i]
                | resv_clr_i[i] | lowest[i];
      next_st[i]     = st[i];
      next_by_reg[i] = by_reg[i];
      next_cnt[i]    = cnt[i];
      unique case (st[i])
        cclpc_pkg::CCLPC_RUN: begin
          if (req_ok && req_core_i == i[$clog2(NCORES)-1:0] &&
              req_state_i != cclpc_pkg::REQ_RUN) begin
            next_by_reg[i] = 1'b1;
            next_st[i] = (req_state_i == cclpc_pkg::REQ_DEEP) ?
                         cclpc_pkg::CCLPC_DEEP : cclpc_pkg::CCLPC_LIGHT;
          end else if (t0w[i] && t1w[i]) begin
            next_by_reg[i] = 1'b0;
            next_st[i] = cclpc_pkg::CCLPC_DEEP;
          end else if (t0w[i] || t1w[i]) begin
            next_by_reg[i] = 1'b0;
            next_st[i] = cclpc_pkg::CCLPC_LIGHT;
          end
        end
        cclpc_pkg::CCLPC_LIGHT: begin
          if (wake_v[i] || wake_wr[i])
            next_st[i] = cclpc_pkg::CCLPC_RUN;
          else if (cl_go || (t0w[i] && t1w[i]))
            next_st[i] = cclpc_pkg::CCLPC_DEEP;
        end
        cclpc_pkg::CCLPC_DEEP_ENT: next_st[i] = cclpc_pkg::CCLPC_DEEP;
        cclpc_pkg::CCLPC_DEEP: begin
          if (wake_v[i] || wake_wr[i]) begin
            next_st[i]  = cclpc_pkg::CCLPC_WAKE_PWR;
            next_cnt[i] = CW'(cclpc_pkg::PWR_RAMP_CYCLES);
          end
        end
        cclpc_pkg::CCLPC_WAKE_PWR: begin
          next_cnt[i] = cnt[i] - 1'b1;
          if (cnt[i] == CW'(1)) begin
            next_st[i]  = cclpc_pkg::CCLPC_WAKE_CLK;
            next_cnt[i] = CW'(cclpc_pkg::CLK_RESTORE_CYCLES);
          end
        end
        cclpc_pkg::CCLPC_WAKE_CLK: begin
          next_cnt[i] = cnt[i] - 1'b1;
          if (cnt[i] == CW'(1))
            next_st[i] = cclpc_pkg::CCLPC_RUN;
        end
        default: next_st[i] = cclpc_pkg::CCLPC_RUN;
      endcase
    end
  end

  // Kept apart from the sequencer so the cluster gate forms no loop
  always_comb begin
    for (int i = 0; i < NCORES; i++)
      light_v[i] = st[i] == cclpc_pkg::CCLPC_LIGHT;
  end
  assign all_light = &light_v;

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NCORES; i++) begin
      if (!rst_n_i) begin
        st[i]  <= cclpc_pkg::CCLPC_RUN;
        cnt[i] <= '0;
      end else begin
        st[i]  <= next_st[i];
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // Thread wait flags: set on wait, cleared on return to run; set wins
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      by_reg <= '0;
      t0w    <= '0;
      t1w    <= '0;
    end else begin
      by_reg <= next_by_reg;
      for (int i = 0; i < NCORES; i++) begin
        t0w[i] <= wait_t0_i[i] | (t0w[i] &
                  next_st[i] != cclpc_pkg::CCLPC_RUN);
        t1w[i] <= wait_t1_i[i] | (t1w[i] &
                  next_st[i] != cclpc_pkg::CCLPC_RUN);
      end
    end
  end

  // ****************************************
  // Core control outputs
  // ****************************************
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < NCORES; i++) begin
      if (!rst_n_i) begin
        fetch_en_o[i]      <= 1'b1;
        snoop_en_o[i]      <= 1'b1;
        core_clk_en_o[i]   <= 1'b1;
        core_pwr_full_o[i] <= 1'b1;
        retain_o[i]        <= 1'b0;
        core_asleep_o[i]   <= 1'b0;
      end else begin
        fetch_en_o[i]    <= next_st[i] == cclpc_pkg::CCLPC_RUN;
        snoop_en_o[i]    <= next_st[i] == cclpc_pkg::CCLPC_RUN ||
                            next_st[i] == cclpc_pkg::CCLPC_LIGHT;
        core_clk_en_o[i] <= next_st[i] == cclpc_pkg::CCLPC_RUN ||
                            next_st[i] == cclpc_pkg::CCLPC_LIGHT ||
                            next_st[i] == cclpc_pkg::CCLPC_WAKE_CLK;
        core_pwr_full_o[i] <= next_st[i] != cclpc_pkg::CCLPC_DEEP &&
                              next_st[i] != cclpc_pkg::CCLPC_WAKE_PWR;
        retain_o[i]      <= next_st[i] == cclpc_pkg::CCLPC_DEEP ||
                            next_st[i] == cclpc_pkg::CCLPC_WAKE_PWR;
        core_asleep_o[i] <= next_st[i] != cclpc_pkg::CCLPC_RUN;
      end
    end
  end

  // ****************************************
  // Cluster, pool, blocks, transmit idle, VID
  // ****************************************
  logic [TW-1:0] tx_cnt;
  logic          cl_deep;
  logic [NBLK-1:0] blk_off;
  wire  cl_any_run = |(fetch_en_o);

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cl_deep        <= 1'b0;
      cluster_deep_o <= 1'b0;
      pool_wake_o    <= '0;
      blk_clk_en_o   <= '1;
      blk_off        <= '0;
      tx_cnt         <= '0;
      tx_lpi_o       <= 1'b0;
    end else begin
      if (cl_go)
        cl_deep <= 1'b1;
      else if (cl_any_run)
        cl_deep <= 1'b0;
      cluster_deep_o <= cl_go | (cl_deep & ~cl_any_run);
      pool_wake_o    <= lowest;
      // Static disable is sticky until chip reset; auto gating
      // reopens the clock the cycle after work arrives
      blk_off      <= blk_off | blk_disable_i;
      blk_clk_en_o <= blk_work_i & ~blk_disable_i & ~blk_off;
      if (tx_s2) begin
        tx_cnt   <= '0;
        tx_lpi_o <= 1'b0;
      end else if (tx_cnt != TW'(TX_IDLE_CYCLES)) begin
        tx_cnt <= tx_cnt + 1'b1;
      end else begin
        tx_lpi_o <= 1'b1;
      end
    end
  end

  // Factory-programmed voltage identification, read-only
  always_ff @(posedge clk_i) begin
    vid_o <= cclpc_pkg::VID_DEFAULT;
  end

endmodule // cclpc_ctrl

// file: dv/cclpc_ctrl_checker.sv
// Checker: port relations of the low-power controller
`timescale 1ns/1ns
module cclpc_checker #(
  parameter int NCORES         = 4,
  parameter int NBLK           = 8,
  parameter int TX_IDLE_CYCLES = 10
) (
  // Clock, reset and inputs
  input wire logic                      clk_i,
  input wire logic                      rst_n_i,
  input wire logic                      req_valid_i,
  input wire logic [$clog2(NCORES)-1:0] req_src_i,
  input wire logic [$clog2(NCORES)-1:0] req_core_i,
  input wire logic [1:0]                req_state_i,
  input wire logic [NCORES-1:0]         req_perm_i,
  input wire logic                      cluster_deep_req_i,
  input wire logic                      l2_flushed_i,
  input wire logic [NCORES-1:0]         irq_i,
  input wire logic [NBLK-1:0]           blk_work_i,
  input wire logic [NBLK-1:0]           blk_disable_i,
  input wire logic                      tx_active_i,
  // Outputs watched
  input wire logic [NCORES-1:0]         fetch_en_o,
  input wire logic [NCORES-1:0]         snoop_en_o,
  input wire logic [NCORES-1:0]         core_clk_en_o,
  input wire logic [NCORES-1:0]         core_pwr_full_o,
  input wire logic [NCORES-1:0]         retain_o,
  input wire logic                      cluster_deep_o,
  input wire logic [NBLK-1:0]           blk_clk_en_o,
  input wire logic                      tx_lpi_o,
  input wire logic [7:0]                vid_o
);
  // ****
  // Helper state
  // ****
  logic [NBLK-1:0] dis_seen;
  logic [15:0]     idle_cnt;
  wire  [NBLK-1:0] live = blk_work_i & ~blk_disable_i & ~dis_seen;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dis_seen <= '0;
      idle_cnt <= 16'h0000;
    end else begin
      dis_seen <= dis_seen | blk_disable_i;
      idle_cnt <= tx_active_i ? 16'h0000 : idle_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_blk_wake: assert property (
    (blk_clk_en_o & $past(live)) == $past(live))
    else $error("block clock late after work");
  chk_blk_static: assert property (
    $past(rst_n_i) |-> (blk_clk_en_o & $past(dis_seen)) == '0)
    else $error("disabled block clock came back");
  chk_lpi_early: assert property (
    $rose(tx_lpi_o) |-> idle_cnt >= TX_IDLE_CYCLES)
    else $error("low power idle too early");
  chk_lpi_late: assert property (
    idle_cnt == TX_IDLE_CYCLES + 6 |-> tx_lpi_o)
    else $error("low power idle missing");
  chk_deep_gated: assert property (
    (~core_pwr_full_o & (fetch_en_o | snoop_en_o | core_clk_en_o
      | ~retain_o)) == '0)
    else $error("low supply without gating");
  chk_fetch_power: assert property (
    (fetch_en_o & ~(core_clk_en_o & core_pwr_full_o)) == '0)
    else $error("fetch before supply and clock");
  chk_light_write: assert property (
    req_valid_i && req_perm_i[req_src_i] && fetch_en_o[req_core_i]
    && req_state_i == cclpc_pkg::REQ_LIGHT
    |=> !fetch_en_o[$past(req_core_i)] && snoop_en_o[$past(req_core_i)])
    else $error("light sleep write not applied");
  chk_deep_exit: assert property (
    !core_pwr_full_o[NCORES-1] && irq_i[NCORES-1]
    |-> ##[1:100] fetch_en_o[NCORES-1])
    else $error("deep exit too slow");
  chk_cluster_gate: assert property (
    cluster_deep_req_i && !l2_flushed_i && !cluster_deep_o
    |=> !cluster_deep_o)
    else $error("cluster deep without flush");
  chk_vid_value: assert property (
    vid_o == cclpc_pkg::VID_DEFAULT)
    else $error("voltage id wrong");
endmodule // cclpc_checker

bind cclpc_ctrl cclpc_checker #(
  .NCORES(NCORES), .NBLK(NBLK), .TX_IDLE_CYCLES(TX_IDLE_CYCLES)
) i_cclpc_checker (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i),
  .req_src_i(req_src_i), .req_core_i(req_core_i), .req_state_i(req_state_i),
  .req_perm_i(req_perm_i), .cluster_deep_req_i(cluster_deep_req_i),
  .l2_flushed_i(l2_flushed_i), .irq_i(irq_i), .blk_work_i(blk_work_i),
  .blk_disable_i(blk_disable_i), .tx_active_i(tx_active_i),
  .fetch_en_o(fetch_en_o), .snoop_en_o(snoop_en_o),
  .core_clk_en_o(core_clk_en_o), .core_pwr_full_o(core_pwr_full_o),
  .retain_o(retain_o), .cluster_deep_o(cluster_deep_o),
  .blk_clk_en_o(blk_clk_en_o), .tx_lpi_o(tx_lpi_o), .vid_o(vid_o));

// file: dv/cclpc_core_model.sv
// Thread model: wait commands become one-cycle wait pulses
`timescale 1ns/1ns
module cclpc_core_model #(
  parameter int NCORES = 4
) (
  // Clock and commands
  input  wire logic [0:0]        clk_i,
  input  wire logic [NCORES-1:0] t0_cmd_i,
  input  wire logic [NCORES-1:0] t1_cmd_i,
  // Wait pulses
  output logic      [NCORES-1:0] wait_t0_o,
  output logic      [NCORES-1:0] wait_t1_o
);
  logic [NCORES-1:0] t0_prev;
  logic [NCORES-1:0] t1_prev;

  // Each thread waits on its own, once per command
  always_ff @(posedge clk_i) begin
    t0_prev <= t0_cmd_i;
    t1_prev <= t1_cmd_i;
  end
  assign wait_t0_o = t0_cmd_i & ~t0_prev;
  assign wait_t1_o = t1_cmd_i & ~t1_prev;
endmodule // cclpc_core_model

// file: dv/cclpc_ctrl_test.sv
// Testbench: low-power controller scenarios
`timescale 1ns/1ns
module cclpc_ctrl_test;
  // ****
  // Signals
  // ****
  localparam int TXI = 10;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        rv      = 1'b0;
  logic [9:0]  rq      = 10'h000;
  logic        cdr     = 1'b0;
  logic        l2f     = 1'b0;
  logic        tx      = 1'b1;
  logic [3:0]  t0c     = 4'h0;
  logic [3:0]  t1c     = 4'h0;
  logic [7:0]  work    = 8'h00;
  logic [7:0]  dis     = 8'h00;
  logic [3:0]  ev [5]  = '{default: 4'h0};
  logic [3:0]  wt0, wt1, fe, sn, rt, asl, pw;
  logic [15:0] pd      = 16'h0000;
  logic [15:0] pth     = 16'h0004;
  logic [7:0]  bce, vid;
  logic        cd, lpi;
  int          bad_count  = 0;
  int          n_compared = 0;
  int          w;
  // Rows: permission, source, core, state, then expected fetch and snoop
  logic [11:0] rows [7] = '{12'hF45, 12'hF43, 12'hF55, 12'hF51, 12'hE11,
                            12'hF93, 12'hF38};

  always #10 clk_i = ~clk_i;

  cclpc_ctrl #(.TX_IDLE_CYCLES(TXI)) i_cclpc_ctrl (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(rv),
    .req_src_i(rq[5:4]), .req_core_i(rq[3:2]), .req_state_i(rq[1:0]),
    .req_perm_i(rq[9:6]), .cluster_deep_req_i(cdr), .l2_flushed_i(l2f),
    .wait_t0_i(wt0), .wait_t1_i(wt1), .ext_trig_i(ev[0]), .irq_i(ev[1]),
    .doorbell_i(ev[2]), .stash_i(ev[3]), .resv_clr_i(ev[4]),
    .pool_depth_i(pd), .pool_thresh_i(pth),
    .blk_work_i(work), .blk_disable_i(dis), .tx_active_i(tx),
    .fetch_en_o(fe), .snoop_en_o(sn), .core_clk_en_o(),
    .core_pwr_full_o(), .retain_o(rt), .core_asleep_o(asl),
    .cluster_deep_o(cd), .pool_wake_o(pw), .blk_clk_en_o(bce),
    .tx_lpi_o(lpi), .vid_o(vid));
  cclpc_core_model i_cclpc_core_model (.clk_i(clk_i), .t0_cmd_i(t0c),
    .t1_cmd_i(t1c), .wait_t0_o(wt0), .wait_t1_o(wt1));

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task req(input logic [9:0] r);
    @(posedge clk_i);
    rq <= r;
    rv <= 1'b1;
    @(posedge clk_i);
    rv <= 1'b0;
  endtask
  task thr(input logic [3:0] a, input logic [3:0] b);
    @(posedge clk_i);
    t0c <= a;
    t1c <= b;
    @(posedge clk_i);
    t0c <= 4'h0;
    t1c <= 4'h0;
  endtask
  task evp(input int k, input logic [3:0] m);
    @(posedge clk_i);
    ev[k] <= m;
    @(posedge clk_i);
    ev[k] <= 4'h0;
  endtask
  task wcore(input int c, input logic [1:0] e);
    repeat (3) @(negedge clk_i);
    for (w = 0; w < 200 && {fe[c], sn[c]} !== e; w++) @(negedge clk_i);
    cmp({6'h00, fe[c], sn[c]}, {6'h00, e});
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Ten thousand cycles, many times the few hundred the tests take
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    cmp(vid, cclpc_pkg::VID_DEFAULT);
    foreach (rows[i]) begin
      req(rows[i][11:2]);
      wcore(rows[i][5:4], rows[i][1:0]);
    end
    cmp({7'h00, rt[3]}, 8'h01);
    evp(1, 4'h8);
    for (w = 0; w < 150 && fe[3] !== 1'b1; w++) @(negedge clk_i);
    cmp({7'h00, w <= 100}, 8'h01);
    thr(4'h4, 4'h0);
    wcore(2, 2'b01);
    for (int k = 0; k < 5; k++) begin
      evp(k, 4'h4);
      wcore(2, 2'b11);
      thr(4'h4, 4'h0);
    end
    thr(4'h0, 4'h4);
    wcore(2, 2'b00);
    evp(1, 4'h4);
    wcore(2, 2'b11);
    for (int c = 0; c < 4; c++) req({4'hF, 2'(c), 2'(c), 2'h1});
    wcore(3, 2'b01);
    for (int n = 0; n < 2; n++) begin
      @(posedge clk_i);
      l2f <= n[0];
      cdr <= 1'b1;
      @(posedge clk_i);
      cdr <= 1'b0;
      repeat (3) @(negedge clk_i);
      for (w = 0; w < 50 && cd !== n[0]; w++) @(negedge clk_i);
      cmp({7'h00, cd}, {7'h00, n[0]});
    end
    // Pool over threshold for one cycle wakes only the lowest core
    @(posedge clk_i);
    pd <= 16'h0005;
    @(posedge clk_i);
    pd <= 16'h0000;
    @(negedge clk_i);
    cmp({4'h0, pw}, 8'h01);
    wcore(0, 2'b11);
    cmp({4'h0, asl}, 8'h0E);
    @(posedge clk_i);
    tx <= 1'b0;
    for (w = 0; w < TXI + 8 && lpi !== 1'b1; w++) @(negedge clk_i);
    repeat (8) @(negedge clk_i);
    cmp({7'h00, lpi}, 8'h01);
    @(posedge clk_i);
    tx <= 1'b1;
    repeat (4) @(negedge clk_i);
    cmp({7'h00, lpi}, 8'h00);
    @(posedge clk_i);
    work <= 8'hA5;
    @(posedge clk_i);
    @(negedge clk_i);
    cmp(bce, 8'hA5);
    @(posedge clk_i);
    work <= 8'hFF;
    dis <= 8'h04;
    @(posedge clk_i);
    dis <= 8'h00;
    repeat (2) @(negedge clk_i);
    cmp(bce, 8'hFB);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    cmp(bce, 8'hFF);
    give_verdict();
  end
endmodule // cclpc_ctrl_test
